/* common/timer_capture_reload_consts.svh */
/*
  Constants for the timer/capture/reload unit: register byte offsets,
  control bit positions, status bit positions, reset values and the
  internal prescale count. Assumes inclusion by bare name.
*/
`ifndef TIMER_CAPTURE_RELOAD_CONSTS_SVH
`define TIMER_CAPTURE_RELOAD_CONSTS_SVH

// ==========================================================================
// Register byte offsets (one aligned 32-bit word each).
`define OFF_CTRL       8'h00
`define OFF_COUNT_LO   8'h04
`define OFF_COUNT_HI   8'h08
`define OFF_CAPT_LO    8'h0c
`define OFF_CAPT_HI    8'h10
`define OFF_STATUS     8'h14
`define OFF_MASK       8'h18

// ==========================================================================
// Control register bit positions.
`define BIT_OVF_FLAG   7
`define BIT_EXT_FLAG   6
`define BIT_RX_SEL     5
`define BIT_TX_SEL     4
`define BIT_EXT_EN     3
`define BIT_RUN        2
`define BIT_CNT_SRC    1
`define BIT_CAP_RL     0

// ==========================================================================
// Status and mask bit positions.
`define ST_OVF         0
`define ST_EXT         1

// ==========================================================================
// Reset values and timing.
`define RST_CTRL       8'h00
`define RST_COUNT      16'h0000
`define RST_CAPT       16'h0000
`define RST_MASK       2'h0
`define PRESCALE_DIV   12
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

/* common/timer_capture_reload_pkg.sv */
/*
  Types for the timer/capture/reload unit: the working mode.
  Assumes nothing of its surroundings.
*/
package timer_capture_reload_pkg;

  // ========================================================================
  // Working mode of the timer.
  typedef enum logic [1:0] {
    MODE_OFF     = 2'b00,
    MODE_RELOAD  = 2'b01,
    MODE_CAPTURE = 2'b10,
    MODE_BAUD    = 2'b11
  } timer_mode_t;

endpackage

/* hw/pin_fall_detect.sv */
/*
  Two-flop synchroniser and falling-edge detector for one pin.
  Assumes the pin is asynchronous to clk and idles high.
*/
`timescale 1ns/10ps

module pin_fall_detect (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pin,
  output logic      fall
);

  logic meta;
  logic sync;
  logic prev;

  // ========================================================================
  // Resetting to one keeps a pin that idles high from looking like an edge at
  // release; a pin held low at release still gives one edge two clocks later.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  // A sampled high followed by a sampled low is one edge.
  assign fall = prev & ~sync;

  property p_fall_once;
    @(posedge clk) disable iff (reset)
    fall |=> !fall;
  endproperty
  a_fall_once: assert property (p_fall_once)
    else $error("One falling edge was reported twice.");

endmodule

/* hw/tick_divider.sv */
/*
  Internal tick source: one-cycle pulse every DIV clocks.
  Assumes one clock domain with synchronous active-high reset.
*/
`timescale 1ns/10ps
`include "timer_capture_reload_consts.svh"

module tick_divider #(
  parameter int DIV = `PRESCALE_DIV
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick
);

  localparam int W = $clog2(DIV);

  logic [W-1:0] cnt;

  // ========================================================================
  // Elaboration check: a divider below two cannot space its ticks.
  if (DIV < 2) begin : g_bad_div
    $error("DIV must be at least 2");
  end

  // Free-running count; the tick marks its last state.
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= '0;
    end else if (cnt == W'(DIV - 1)) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + W'(1);
    end
  end

  assign tick = (cnt == W'(DIV - 1));

  property p_tick_spacing;
    @(posedge clk) disable iff (reset)
    tick |=> !tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("Internal tick came on two cycles in a row.");

endmodule

/* hw/timer_capture_reload_unit.sv */
/*
  Sixteen-bit timer/counter with capture, auto-reload and baud pulse
  modes, registers on an AXI4-Lite slave, one level interrupt.
  Assumes one clock, synchronous active-high reset, asynchronous pins
  for the count input and the trigger, and a same-clock overflow pulse
  from the other timer for the serial clock selection.
*/
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "timer_capture_reload_consts.svh"

module timer_capture_reload_unit (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic [7:0]          awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [7:0]          araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire logic                count_pin,
  input  wire logic                ext_trigger_pin,
  input  wire logic                other_timer_overflow,
  output logic                     timer_baud_pulse,
  output logic                     tx_clock_pulse,
  output logic                     rx_clock_pulse,
  output timer_capture_reload_pkg::timer_mode_t timer_mode,
  output logic                     irq
);

  logic        aw_held;
  logic        w_held;
  logic [7:0]  waddr;
  logic [7:0]  wbyte;
  logic        wlane;
  logic        wr_fire;
  logic        rx_sel;
  logic        serial_tx_clock_select;
  logic        ext_trigger_enable;
  logic        timer_run_bit;
  logic        count_source_select;
  logic        capture_reload_select;
  logic        overflow_flag;
  logic        ext_event_flag;
  logic [1:0]  mask;
  logic [15:0] count;
  logic [15:0] capture;
  logic        tick;
  logic        cnt_fall;
  logic        trig_fall;
  logic        baud;
  logic        count_en;
  logic        ovf_evt;
  logic        trig_ok;
  logic        cap_evt;
  logic        reload_evt;
  logic        reload_tick;
  logic        sw_cnt_wr;
  logic [1:0]  status;

  // ========================================================================
  // Helpers.
  tick_divider #(.DIV(`PRESCALE_DIV)) u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );

  pin_fall_detect u_cnt_pin (
    .clk   (clk),
    .reset (reset),
    .pin   (count_pin),
    .fall  (cnt_fall)
  );

  pin_fall_detect u_trig_pin (
    .clk   (clk),
    .reset (reset),
    .pin   (ext_trigger_pin),
    .fall  (trig_fall)
  );

  // Mode decode from the run bit and the selects.
  function automatic timer_capture_reload_pkg::timer_mode_t mode_of(
      input logic run, input logic srl, input logic cap);
    if (!run) begin
      mode_of = timer_capture_reload_pkg::MODE_OFF;
    end else if (srl) begin
      mode_of = timer_capture_reload_pkg::MODE_BAUD;
    end else if (cap) begin
      mode_of = timer_capture_reload_pkg::MODE_CAPTURE;
    end else begin
      mode_of = timer_capture_reload_pkg::MODE_RELOAD;
    end
  endfunction

  // ========================================================================
  // Counting events.
  assign baud     = rx_sel | serial_tx_clock_select;
  assign count_en = timer_run_bit &
                    (count_source_select ? cnt_fall : tick);
  assign ovf_evt  = count_en & (count == 16'hffff);
  // Trigger edges count only when enabled and not clocking the port.
  assign trig_ok  = trig_fall & ext_trigger_enable & ~baud;
  assign cap_evt  = trig_ok & capture_reload_select;
  // Serial clocking overrides the capture bit.
  assign reload_tick = ovf_evt &
                       (baud | ~capture_reload_select);
  assign reload_evt  = reload_tick |
                       (trig_ok & ~capture_reload_select);
  assign status   = {ext_event_flag, overflow_flag};

  // ========================================================================
  // Write channel: address and data are taken in either order, the write
  // lands when both are held, and ready returns after the response.
  assign wr_fire = aw_held & w_held & ~bvalid;

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      awready <= 1'b1;
      waddr   <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      awready <= 1'b0;
      waddr   <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      w_held <= 1'b0;
      wready <= 1'b1;
      wbyte  <= 8'h00;
      wlane  <= 1'b0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      wready <= 1'b0;
      wbyte  <= wdata[7:0];
      wlane  <= wstrb[0];
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Unmapped offsets answer with a slave error and change nothing.
  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= (waddr > `OFF_MASK || waddr[1:0] != 2'h0) ?
                `RESP_SLVERR : `RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  assign sw_cnt_wr = wr_fire & wlane &
                     (waddr == `OFF_COUNT_LO || waddr == `OFF_COUNT_HI);

  // ========================================================================
  // Control bits; the two flag positions are read-only here.
  always_ff @(posedge clk) begin
    if (reset) begin
      {rx_sel, serial_tx_clock_select, ext_trigger_enable,
       timer_run_bit, count_source_select,
       capture_reload_select} <= 6'(`RST_CTRL);
    end else if (wr_fire && wlane && waddr == `OFF_CTRL) begin
      rx_sel                 <= wbyte[`BIT_RX_SEL];
      serial_tx_clock_select <= wbyte[`BIT_TX_SEL];
      ext_trigger_enable     <= wbyte[`BIT_EXT_EN];
      timer_run_bit          <= wbyte[`BIT_RUN];
      count_source_select    <= wbyte[`BIT_CNT_SRC];
      capture_reload_select  <= wbyte[`BIT_CAP_RL];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask <= `RST_MASK;
    end else if (wr_fire && wlane && waddr == `OFF_MASK) begin
      mask <= wbyte[1:0];
    end
  end

  // Sticky flags: writing one clears, but a new event in the same cycle
  // wins so that no event is lost. Baud mode leaves the overflow flag
  // alone because those overflows are serial clock ticks.
  always_ff @(posedge clk) begin
    if (reset) begin
      overflow_flag  <= 1'b0;
      ext_event_flag <= 1'b0;
    end else begin
      if (ovf_evt && !baud) begin
        overflow_flag <= 1'b1;
      end else if (wr_fire && wlane && waddr == `OFF_STATUS &&
                   wbyte[`ST_OVF]) begin
        overflow_flag <= 1'b0;
      end
      if (trig_ok) begin
        ext_event_flag <= 1'b1;
      end else if (wr_fire && wlane && waddr == `OFF_STATUS &&
                   wbyte[`ST_EXT]) begin
        ext_event_flag <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Counter. A software write to a count byte wins over counting.
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= `RST_COUNT;
    end else if (wr_fire && wlane && waddr == `OFF_COUNT_LO) begin
      count[7:0] <= wbyte;
    end else if (wr_fire && wlane && waddr == `OFF_COUNT_HI) begin
      count[15:8] <= wbyte;
    end else if (reload_evt) begin
      count <= capture;
    end else if (count_en) begin
      count <= count + 16'h0001;
    end
  end

  // Capture registers double as the reload value.
  always_ff @(posedge clk) begin
    if (reset) begin
      capture <= `RST_CAPT;
    end else if (cap_evt) begin
      capture <= count;
    end else if (wr_fire && wlane && waddr == `OFF_CAPT_LO) begin
      capture[7:0] <= wbyte;
    end else if (wr_fire && wlane && waddr == `OFF_CAPT_HI) begin
      capture[15:8] <= wbyte;
    end
  end

  // ========================================================================
  // Serial clock pulses, mode and interrupt, all registered.
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_baud_pulse <= 1'b0;
      tx_clock_pulse   <= 1'b0;
      rx_clock_pulse   <= 1'b0;
    end else begin
      timer_baud_pulse <= reload_tick;
      tx_clock_pulse   <= serial_tx_clock_select ? reload_tick
                          : other_timer_overflow;
      rx_clock_pulse   <= rx_sel ? reload_tick : other_timer_overflow;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      timer_mode <= timer_capture_reload_pkg::MODE_OFF;
    end else begin
      timer_mode <= mode_of(timer_run_bit, baud,
                            capture_reload_select);
    end
  end

  // One shared request; software reads status to find the cause.
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // ========================================================================
  // Read channel: one read at a time, answered one cycle after address.
  always_ff @(posedge clk) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= `RESP_OKAY;
      case (araddr)
        `OFF_CTRL:     rdata <= {24'h000000, overflow_flag, ext_event_flag,
                                 rx_sel, serial_tx_clock_select,
                                 ext_trigger_enable, timer_run_bit,
                                 count_source_select, capture_reload_select};
        `OFF_COUNT_LO: rdata <= {24'h000000, count[7:0]};
        `OFF_COUNT_HI: rdata <= {24'h000000, count[15:8]};
        `OFF_CAPT_LO:  rdata <= {24'h000000, capture[7:0]};
        `OFF_CAPT_HI:  rdata <= {24'h000000, capture[15:8]};
        `OFF_STATUS:   rdata <= {30'h0, status};
        `OFF_MASK:     rdata <= {30'h0, mask};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ========================================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_trig_unmasked;
    trig_ok && mask[`ST_EXT];
  endsequence

  property p_count_ext;
    (timer_run_bit && count_source_select && cnt_fall && !sw_cnt_wr &&
     !reload_evt) |=> count == $past(count) + 16'h0001;
  endproperty
  a_count_ext: assert property (p_count_ext)
    else $error("Pin edge did not advance the count.");

  property p_count_stop;
    (!timer_run_bit && !sw_cnt_wr && !reload_evt) |=> $stable(count);
  endproperty
  a_count_stop: assert property (p_count_stop)
    else $error("Count moved while stopped.");

  property p_capture;
    (trig_fall && ext_trigger_enable && capture_reload_select && !baud)
      |=> capture == $past(count);
  endproperty
  a_capture: assert property (p_capture)
    else $error("Trigger did not capture the count.");

  property p_reload;
    (ovf_evt && (baud || !capture_reload_select) && !sw_cnt_wr)
      |=> count == $past(capture) && timer_baud_pulse;
  endproperty
  a_reload: assert property (p_reload)
    else $error("Overflow did not reload and pulse.");

  property p_ignore;
    (trig_fall && (!ext_trigger_enable || baud)) |=> !$rose(ext_event_flag);
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("Ignored trigger set the event flag.");

  property p_ovf_flag;
    (ovf_evt && !baud) |=> overflow_flag;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("Overflow flag not set on rollover.");

  property p_shared_irq;
    s_trig_unmasked |=> ##1 irq;
  endproperty
  a_shared_irq: assert property (p_shared_irq)
    else $error("Unmasked event did not raise the interrupt.");

  property p_mode;
    (timer_run_bit && baud) |=>
      timer_mode == timer_capture_reload_pkg::MODE_BAUD;
  endproperty
  a_mode: assert property (p_mode)
    else $error("Serial clock select did not give baud mode.");

  property p_tx_src;
    (serial_tx_clock_select && reload_tick) |=> tx_clock_pulse;
  endproperty
  a_tx_src: assert property (p_tx_src)
    else $error("Transmit clock missed a reload tick.");

endmodule

/* tb/pin_stimulus_model.sv */
/*
  Far-side model of the timer's pins: the external count input, the
  trigger input and the other timer's overflow pulse.
  Assumes the bench calls its tasks right after a rising clock edge.
*/
`timescale 1ns/10ps

// ==========================================================================
// Pin stimulus.
module pin_stimulus_model (
  input  wire logic clk,
  output logic      count_pin,
  output logic      ext_trigger_pin,
  output logic      other_timer_overflow
);
  // Pins idle high as if pulled up; the overflow pulse idles low.
  initial begin
    count_pin = 1'b1;
    ext_trigger_pin = 1'b1;
    other_timer_overflow = 1'b0;
  end

  // Each level is held three clocks so the sampler sees one clean edge.
  task automatic fall(input bit trig, input int n);
    repeat (n) begin
      @(posedge clk);
      if (trig) ext_trigger_pin <= 1'b0;
      else count_pin <= 1'b0;
      repeat (3) @(posedge clk);
      ext_trigger_pin <= 1'b1;
      count_pin <= 1'b1;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask

  // One-cycle overflow pulse from the other timer, then settle time.
  task automatic other_pulse();
    @(posedge clk);
    other_timer_overflow <= 1'b1;
    @(posedge clk);
    other_timer_overflow <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* tb/timer_capture_reload_unit_tb_top.sv */
/*
  Self-checking bench for the timer/capture/reload unit: AXI4-Lite
  master tasks, a read/write result queue and a pin stimulus model.
  Assumes the design's constants header and mode package.
*/
`timescale 1ns/10ps
`include "timer_capture_reload_consts.svh"
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
  num_errors++; $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); \
  end end

// ==========================================================================
// Bench top.
module timer_capture_reload_unit_tb_top;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, seen, held;
  logic [3:0]  wstrb = 4'h0;
  logic        bready = 1'b1, rready = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic        count_pin, ext_trigger_pin, other_timer_overflow;
  logic        timer_baud_pulse, tx_clock_pulse, rx_clock_pulse;
  timer_capture_reload_pkg::timer_mode_t timer_mode;
  logic [34:0] exp_q[$];
  logic [34:0] note;
  int          num_errors = 0, checks_done = 0;
  int          n_baud = 0, n_tx = 0, n_rx = 0, i;
  int          seed = 32'ha9955767;
  logic [7:0]  rlo;
  logic [7:0]  mv[6] = '{8'h00, 8'h04, 8'h05, 8'h24, 8'h14, 8'h34};
  logic [1:0]  me[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};

  always #20 clk = ~clk;

  timer_capture_reload_unit u_dut (.clk(clk), .reset(reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .count_pin(count_pin),
    .ext_trigger_pin(ext_trigger_pin),
    .other_timer_overflow(other_timer_overflow),
    .timer_baud_pulse(timer_baud_pulse), .tx_clock_pulse(tx_clock_pulse),
    .rx_clock_pulse(rx_clock_pulse), .timer_mode(timer_mode), .irq(irq));

  pin_stimulus_model u_pins (.clk(clk), .count_pin(count_pin),
    .ext_trigger_pin(ext_trigger_pin),
    .other_timer_overflow(other_timer_overflow));

  // Result watcher: every completed response takes the oldest note.
  always @(posedge clk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      if (exp_q.size() == 0) begin
        `CHK("note queue", 1'b1, 1'b0)
      end else begin
        note = exp_q.pop_front();
        if (note[34] && rvalid) `CHK("read", note[33:0], {rresp, rdata})
        if (note[34] && bvalid) `CHK("bresp", note[33:32], bresp)
      end
    end
  end

  // Pulse counters; scenarios compare differences, never absolutes.
  always @(posedge clk) begin
    n_baud <= n_baud + int'(timer_baud_pulse);
    n_tx <= n_tx + int'(tx_clock_pulse);
    n_rx <= n_rx + int'(rx_clock_pulse);
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // A write offers address and data together and waits for the answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    exp_q.push_back({1'b1, er, 32'h0});
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 50);
    if (n >= 50) begin num_errors++; end_sim(); end
  endtask

  // A read notes its expectation first; chk clear leaves it unchecked.
  task automatic rd(input logic [7:0] a, input logic [1:0] er,
                    input logic [31:0] ed, input logic chk);
    int n;
    n = 0;
    exp_q.push_back({chk, er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 50);
    seen = rdata;
    if (n >= 50) begin num_errors++; end_sim(); end
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, {24'h0, v[7:0]}, 4'h1, `RESP_OKAY);
    wr(a + 8'h04, {24'h0, v[15:8]}, 4'h1, `RESP_OKAY);
  endtask

  task automatic rd16(input logic [7:0] a, input logic [15:0] v);
    rd(a, `RESP_OKAY, {24'h0, v[7:0]}, 1'b1);
    rd(a + 8'h04, `RESP_OKAY, {24'h0, v[15:8]}, 1'b1);
  endtask

  // ========================================================================
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // Reset values, unmapped and unaligned places.
    for (i = 0; i <= 8'h18; i += 4) rd(8'(i), `RESP_OKAY, 32'h0, 1'b1);
    rd(8'h1c, `RESP_SLVERR, 32'h0, 1'b1);
    rd(8'h02, `RESP_SLVERR, 32'h0, 1'b1);
    wr(8'h20, 32'h0, 4'hf, `RESP_SLVERR);
    wr(`OFF_CTRL, 32'h04, 4'he, `RESP_OKAY);
    rd(`OFF_CTRL, `RESP_OKAY, 32'h0, 1'b1);
    // Every mode encoding.
    for (i = 0; i < 6; i++) begin
      wr(`OFF_CTRL, {24'h0, mv[i]}, 4'h1, `RESP_OKAY);
      repeat (2) @(posedge clk);
      `CHK("mode", me[i], timer_mode)
    end
    // Internal ticks: about one per twelve clocks, frozen once stopped.
    wr(`OFF_CTRL, 32'h0, 4'h1, `RESP_OKAY);
    wr16(`OFF_COUNT_LO, 16'h0000);
    wr(`OFF_CTRL, 32'h05, 4'h1, `RESP_OKAY);
    repeat (240) @(posedge clk);
    wr(`OFF_CTRL, 32'h01, 4'h1, `RESP_OKAY);
    rd(`OFF_COUNT_LO, `RESP_OKAY, 32'h0, 1'b0);
    held = seen;
    `CHK("ticks", 1'b1, held >= 32'd18 && held <= 32'd22)
    repeat (30) @(posedge clk);
    rd(`OFF_COUNT_LO, `RESP_OKAY, held, 1'b1);
    // Capture mode: pin counting through rollover, then a trigger.
    wr(`OFF_MASK, 32'h03, 4'h1, `RESP_OKAY);
    wr16(`OFF_COUNT_LO, 16'hfffe);
    wr(`OFF_CTRL, 32'h0f, 4'h1, `RESP_OKAY);
    u_pins.fall(1'b0, 3);
    rd(`OFF_STATUS, `RESP_OKAY, 32'h01, 1'b1);
    u_pins.fall(1'b1, 1);
    rd16(`OFF_COUNT_LO, 16'h0001);
    rd16(`OFF_CAPT_LO, 16'h0001);
    rd(`OFF_CTRL, `RESP_OKAY, 32'hcf, 1'b1);
    `CHK("irq set", 1'b1, irq)
    wr(`OFF_STATUS, 32'h01, 4'h1, `RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK("irq ext only", 1'b1, irq)
    wr(`OFF_MASK, 32'h01, 4'h1, `RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    wr(`OFF_STATUS, 32'h03, 4'h1, `RESP_OKAY);
    rd(`OFF_STATUS, `RESP_OKAY, 32'h0, 1'b1);
    // Reload mode: rollover reload, baud pulse, early reload by trigger.
    rlo = 8'($random(seed));
    wr16(`OFF_CAPT_LO, {8'h12, rlo});
    wr16(`OFF_COUNT_LO, 16'hffff);
    wr(`OFF_CTRL, 32'h0e, 4'h1, `RESP_OKAY);
    i = n_baud;
    u_pins.fall(1'b0, 1);
    `CHK("baud pulses", i + 1, n_baud)
    rd16(`OFF_COUNT_LO, {8'h12, rlo});
    u_pins.fall(1'b0, 2);
    u_pins.fall(1'b1, 1);
    rd16(`OFF_COUNT_LO, {8'h12, rlo});
    rd(`OFF_STATUS, `RESP_OKAY, 32'h03, 1'b1);
    wr(`OFF_STATUS, 32'h03, 4'h1, `RESP_OKAY);
    // Trigger disabled: ignored.
    wr(`OFF_CTRL, 32'h06, 4'h1, `RESP_OKAY);
    u_pins.fall(1'b1, 1);
    rd(`OFF_STATUS, `RESP_OKAY, 32'h0, 1'b1);
    // Baud mode forces reload despite capture select; trigger ignored.
    wr16(`OFF_COUNT_LO, 16'hffff);
    wr(`OFF_CTRL, 32'h1f, 4'h1, `RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK("mode baud", 2'h3, timer_mode)
    i = n_tx;
    u_pins.fall(1'b0, 1);
    `CHK("tx pulses", i + 1, n_tx)
    u_pins.fall(1'b1, 1);
    rd16(`OFF_COUNT_LO, {8'h12, rlo});
    rd(`OFF_STATUS, `RESP_OKAY, 32'h0, 1'b1);
    i = n_rx + n_tx;
    u_pins.other_pulse();
    `CHK("rx other", i + 1, n_rx + n_tx)
    end_sim();
  end
endmodule
